// >>> rtl/gsp_protect_core.sv
// Global protect / unprotect decoder with sector protection bits and lock.
// Assumes the host is an SPI master; per-sector commands come from the
// rest of the device as one-cycle pulses on plain ports.
//
// Contract
// [RULE_01] Global operations ride only on status writes
// [RULE_02] Bits 5..2 all ones protect every sector
// [RULE_03] Bits 5..2 all zeros unprotect every sector
// [RULE_04] Mixed bits 5..2 leave sectors unchanged
// [RULE_05] Unlocked, 00h unprotects all, lock stays zero
// [RULE_06] Unlocked, 7Fh protects all, lock stays zero
// [RULE_07] Unlocked, FFh protects all and sets lock
// [RULE_08] Only bit 7 is stored, as lock
// [RULE_09] Status bits 5..2 show pin and summary; the code uses bits 4..2 and bit 5 reads zero
// [RULE_10] Pin low and locked: write fully ignored
// [RULE_11] Pin high and locked: lock loads bit 7 only
// [RULE_12] Host unlocks first, then writes global pattern
// [RULE_13] 0Fh with pin high clears lock only
// [RULE_14] F0h while unlocked sets lock only
// [RULE_15] Sector commands still act after global ones
// [RULE_16] Status write needs write permit latch set
// [RULE_17] Reset leaves every sector protected
// [RULE_18] Update applies at deselect after full byte
// [RULE_19] Sixteen sector bits, updated in one step
`timescale 1ns/1ns
module gsp_protect_core #(
	parameter int NUM_SECTORS = gsp_pkg::NUM_SECTORS,
	parameter int SECT_IDX_W = gsp_pkg::SECT_IDX_W
) (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic reset_i,
	// Serial pins from the host
	input wire logic sck_i,
	input wire logic cs_n_i,
	input wire logic si_i,
	// Write protect pin, asserted low
	input wire logic wp_n_i,
	// Single sector commands from the device command path
	input wire logic sect_cmd_i,
	input wire logic sect_protect_i,
	input wire logic [SECT_IDX_W-1:0] sect_idx_i,
	// Protection state
	output logic [NUM_SECTORS-1:0] sect_prot_o,
	output logic lock_o,
	output logic write_permit_o,
	output logic [7:0] status_o,
	output logic global_done_o
);

	typedef struct packed {
		gsp_pkg::gsp_state_t state;
		logic write_permit_latch;
		logic protect_regs_lock_bit;
		logic [NUM_SECTORS-1:0] sect;
		logic [7:0] wr_data;
		logic [7:0] status;
		logic global_done;
	} gsp_core_state_t;

	gsp_core_state_t core_reg;
	gsp_core_state_t core_next;

	gsp_byte_if link ();

	// ****************************************************************
	// Serial byte receiver
	// ****************************************************************
	gsp_spi_rx u_rx (
		.mclk_i(mclk_i),
		.reset_i(reset_i),
		.sck_i(sck_i),
		.cs_n_i(cs_n_i),
		.si_i(si_i),
		.link(link)
	);

	// ****************************************************************
	// Status write decode
	// ****************************************************************
	// Field of the written byte that selects a global operation
	logic [3:0] global_field;
	logic global_set;
	logic global_clear;
	logic hard_locked;
	logic soft_locked;
	logic wsr_executes;

	assign global_field = core_reg.wr_data[gsp_pkg::SR_GLOBAL_HI:gsp_pkg::SR_GLOBAL_LO];
	// Only the two uniform patterns act; anything else is a no-op on sectors
	assign global_set = (global_field == gsp_pkg::GLOBAL_ALL_ONES); // [RULE_02] [RULE_04]
	assign global_clear = (global_field == gsp_pkg::GLOBAL_ALL_ZEROS); // [RULE_03] [RULE_04]
	// Lock active with pin asserted is a hard lock, else a soft lock
	assign hard_locked = core_reg.protect_regs_lock_bit && !wp_n_i; // [RULE_10]
	assign soft_locked = core_reg.protect_regs_lock_bit && wp_n_i; // [RULE_11]
	// A status write runs only at a clean deselect after its data byte
	assign wsr_executes = link.frame_end && link.frame_aligned && (core_reg.state == gsp_pkg::ST_WSR_FULL)
		&& core_reg.write_permit_latch; // [RULE_16] [RULE_18]

	// ****************************************************************
	// Status summary
	// ****************************************************************
	// Summary of sector bits: none, some or all protected
	logic [1:0] prot_summary;

	always_comb begin
		if (&core_reg.sect) begin
			prot_summary = gsp_pkg::SUM_ALL;
		end else if (|core_reg.sect) begin
			prot_summary = gsp_pkg::SUM_SOME;
		end else begin
			prot_summary = gsp_pkg::SUM_NONE;
		end
	end

	// ****************************************************************
	// Next state
	// ****************************************************************
	// Frame parsing, status write execution and sector commands
	always_comb begin
		core_next = core_reg;
		core_next.global_done = 1'b0;

		// Opcode and data bytes of a frame
		if (link.byte_valid) begin
			unique case (core_reg.state)
				gsp_pkg::ST_OPCODE: begin
					// No dedicated global opcode; only the status write carries it
					case (link.byte_data)
						gsp_pkg::OPC_WRITE_ENABLE: core_next.state = gsp_pkg::ST_WEN;
						gsp_pkg::OPC_WRITE_DISABLE: core_next.state = gsp_pkg::ST_WDIS;
						gsp_pkg::OPC_WRITE_STATUS: core_next.state = gsp_pkg::ST_WSR_WAIT; // [RULE_01]
						default: core_next.state = gsp_pkg::ST_IGNORE;
					endcase
				end
				gsp_pkg::ST_WSR_WAIT: begin
					// First data byte only; later bytes are dropped
					core_next.wr_data = link.byte_data;
					core_next.state = gsp_pkg::ST_WSR_FULL;
				end
				gsp_pkg::ST_WEN,
				gsp_pkg::ST_WDIS,
				gsp_pkg::ST_WSR_FULL,
				gsp_pkg::ST_IGNORE: begin
					core_next.state = core_reg.state;
				end
			endcase
		end

		// End of frame: enable and disable act only if the frame ended on a byte boundary
		if (link.frame_end) begin
			core_next.state = gsp_pkg::ST_OPCODE;
			if (link.frame_aligned && (core_reg.state == gsp_pkg::ST_WEN)) begin
				core_next.write_permit_latch = 1'b1;
			end
			if (link.frame_aligned && (core_reg.state == gsp_pkg::ST_WDIS)) begin
				core_next.write_permit_latch = 1'b0;
			end
			// Any status write frame consumes the permit, done or not
			if ((core_reg.state == gsp_pkg::ST_WSR_WAIT) || (core_reg.state == gsp_pkg::ST_WSR_FULL)) begin
				core_next.write_permit_latch = 1'b0; // [RULE_16]
			end
		end

		// Status write: only the lock bit is stored, bits 5..2 are decoded
		if (wsr_executes) begin
			if (hard_locked) begin
				// Pin low and locked: data discarded, lock cannot drop
				core_next.protect_regs_lock_bit = core_reg.protect_regs_lock_bit; // [RULE_10]
			end else if (soft_locked) begin
				// Unlock first; a global op needs a second write
				core_next.protect_regs_lock_bit = core_reg.wr_data[gsp_pkg::SR_LOCK_BIT]; // [RULE_11] [RULE_12] [RULE_13]
			end else begin
				// Unlocked: 00h, 7Fh, FFh and F0h all fall out of this decode
				core_next.protect_regs_lock_bit = core_reg.wr_data[gsp_pkg::SR_LOCK_BIT]; // [RULE_08] [RULE_07] [RULE_14]
				if (global_set) begin
					core_next.sect = {NUM_SECTORS{1'b1}}; // [RULE_02] [RULE_06] [RULE_07] [RULE_19]
					core_next.global_done = 1'b1;
				end else if (global_clear) begin
					core_next.sect = {NUM_SECTORS{1'b0}}; // [RULE_03] [RULE_05] [RULE_19]
					core_next.global_done = 1'b1;
				end
			end
		end

		// Single sector command; applied after any global step in the same
		// cycle so the sector command has the last word on its own bit
		if (sect_cmd_i && !core_reg.protect_regs_lock_bit) begin
			core_next.sect[sect_idx_i] = sect_protect_i; // [RULE_15]
		end

		// Status image: lock, pin, summary, permit latch; bits 6, 5 and 0 read zero
		core_next.status = '0;
		core_next.status[gsp_pkg::SR_LOCK_BIT] = core_reg.protect_regs_lock_bit;
		core_next.status[gsp_pkg::SR_WP_BIT] = wp_n_i; // [RULE_09]
		core_next.status[gsp_pkg::SR_SUM_HI:gsp_pkg::SR_SUM_LO] = prot_summary; // [RULE_09]
		core_next.status[gsp_pkg::SR_WPL_BIT] = core_reg.write_permit_latch;
	end

	// ****************************************************************
	// State register
	// ****************************************************************
	// Reset protects all sectors so nothing is writable until software asks
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			core_reg.state <= gsp_pkg::ST_OPCODE;
			core_reg.write_permit_latch <= gsp_pkg::RST_WPL;
			core_reg.protect_regs_lock_bit <= gsp_pkg::RST_LOCK;
			core_reg.sect <= {NUM_SECTORS{gsp_pkg::RST_SECT_BIT}}; // [RULE_17]
			core_reg.wr_data <= '0;
			core_reg.status <= '0;
			core_reg.global_done <= 1'b0;
		end else begin
			core_reg <= core_next;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign sect_prot_o = core_reg.sect;
	assign lock_o = core_reg.protect_regs_lock_bit;
	assign write_permit_o = core_reg.write_permit_latch;
	assign status_o = core_reg.status;
	assign global_done_o = core_reg.global_done;

endmodule // gsp_protect_core

// >>> rtl/gsp_pkg.sv
// Package for the global sector protect decoder.
// Assumes a single 50 MHz clock domain and an SPI mode 0/3 host.
package gsp_pkg;

	// ****************************************************************
	// Command opcodes
	// ****************************************************************
	localparam logic [7:0] OPC_WRITE_ENABLE = 8'h06;
	localparam logic [7:0] OPC_WRITE_DISABLE = 8'h04;
	localparam logic [7:0] OPC_WRITE_STATUS = 8'h01;

	// ****************************************************************
	// Status byte layout
	// ****************************************************************
	localparam int SR_LOCK_BIT = 7;
	localparam int SR_GLOBAL_HI = 5;
	localparam int SR_GLOBAL_LO = 2;
	localparam int SR_WP_BIT = 4;
	localparam int SR_SUM_HI = 3;
	localparam int SR_SUM_LO = 2;
	localparam int SR_WPL_BIT = 1;
	localparam logic [3:0] GLOBAL_ALL_ONES = 4'hF;
	localparam logic [3:0] GLOBAL_ALL_ZEROS = 4'h0;
	localparam logic [1:0] SUM_NONE = 2'h0;
	localparam logic [1:0] SUM_SOME = 2'h1;
	localparam logic [1:0] SUM_ALL = 2'h3;

	// ****************************************************************
	// Reset values and sizes
	// ****************************************************************
	localparam int NUM_SECTORS = 16;
	localparam int SECT_IDX_W = 4;
	localparam logic RST_SECT_BIT = 1'b1;
	localparam logic RST_LOCK = 1'b0;
	localparam logic RST_WPL = 1'b0;
	localparam int BITS_PER_BYTE = 8;
	localparam logic [2:0] LAST_BIT = 3'h7;
	localparam logic [2:0] FIRST_BIT = 3'h0;

	// ****************************************************************
	// Command decoder states
	// ****************************************************************
	typedef enum logic [5:0] {
		ST_OPCODE = 6'h01,
		ST_WEN = 6'h02,
		ST_WDIS = 6'h04,
		ST_WSR_WAIT = 6'h08,
		ST_WSR_FULL = 6'h10,
		ST_IGNORE = 6'h20
	} gsp_state_t;

endpackage

// >>> rtl/gsp_byte_if.sv
// Byte link between the SPI receiver and the protection core.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
interface gsp_byte_if;
	logic byte_valid;
	logic [7:0] byte_data;
	logic frame_active;
	logic frame_end;
	logic frame_aligned;

	// Receiver drives, core listens
	modport rx (output byte_valid, output byte_data, output frame_active, output frame_end, output frame_aligned);
	modport core (input byte_valid, input byte_data, input frame_active, input frame_end, input frame_aligned);
endinterface

// >>> rtl/gsp_spi_rx.sv
// SPI byte receiver: oversamples sck and cs_n on the system clock.
// Assumes pins are already synchronous and sck is well below mclk/2.
`timescale 1ns/1ns
module gsp_spi_rx (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic reset_i,
	// Serial pins
	input wire logic sck_i,
	input wire logic cs_n_i,
	input wire logic si_i,
	// Byte link
	gsp_byte_if.rx link
);

	typedef struct packed {
		logic sck_prev;
		logic cs_prev;
		logic [6:0] shift;
		logic [2:0] bit_cnt;
		logic byte_valid;
		logic [7:0] byte_data;
		logic frame_end;
		logic frame_aligned;
	} gsp_rx_state_t;

	gsp_rx_state_t rx_reg;
	gsp_rx_state_t rx_next;

	// ****************************************************************
	// Next state
	// ****************************************************************
	// Bits are taken MSB first on the rising sck edge, as modes 0 and 3 require
	always_comb begin
		rx_next = rx_reg;
		rx_next.sck_prev = sck_i;
		rx_next.cs_prev = cs_n_i;
		rx_next.byte_valid = 1'b0;
		rx_next.frame_end = 1'b0;
		if (cs_n_i) begin
			// Deselect drops any partial byte
			rx_next.bit_cnt = pkg_first();
			rx_next.shift = '0;
			if (!rx_reg.cs_prev) begin
				rx_next.frame_end = 1'b1;
				rx_next.frame_aligned = (rx_reg.bit_cnt == gsp_pkg::FIRST_BIT);
			end
		end else if (sck_i && !rx_reg.sck_prev) begin
			rx_next.shift = {rx_reg.shift[5:0], si_i};
			rx_next.bit_cnt = rx_reg.bit_cnt + 3'h1;
			if (rx_reg.bit_cnt == gsp_pkg::LAST_BIT) begin
				rx_next.byte_valid = 1'b1;
				rx_next.byte_data = {rx_reg.shift, si_i};
			end
		end
	end

	function automatic logic [2:0] pkg_first();
		return gsp_pkg::FIRST_BIT;
	endfunction

	// State register
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			rx_reg <= '{sck_prev: 1'b0, cs_prev: 1'b1, shift: '0, bit_cnt: '0, byte_valid: 1'b0,
				byte_data: '0, frame_end: 1'b0, frame_aligned: 1'b0};
		end else begin
			rx_reg <= rx_next;
		end
	end

	// Link outputs, all from flops
	assign link.byte_valid = rx_reg.byte_valid;
	assign link.byte_data = rx_reg.byte_data;
	assign link.frame_active = !rx_reg.cs_prev;
	assign link.frame_end = rx_reg.frame_end;
	assign link.frame_aligned = rx_reg.frame_aligned;

endmodule // gsp_spi_rx

// >>> verif/gsp_host_model.sv
// Host SPI master model driving the serial pins of the protect core.
// Assumes callers enter its task just after a rising edge of mclk_i.
`timescale 1ns/1ns
module gsp_host_model (
	// Clock
	input wire logic mclk_i,
	// Serial pins toward the device
	output logic sck_o,
	output logic cs_n_o,
	output logic si_o
);
	// ****************************************************************
	// Frame driver
	// ****************************************************************
	// Idle pins: deselected, clock parked low
	initial begin
		sck_o = 1'b0;
		cs_n_o = 1'b1;
		si_o = 1'b0;
	end
	// Wait n edges, then step clear of the edge
	task automatic tick(input int n);
		repeat (n) @(posedge mclk_i);
		#1;
	endtask
	// One frame, MSB first; nbits below a byte multiple aborts it
	task automatic frame(input logic [15:0] data, input int nbits);
		cs_n_o = 1'b0;
		for (int i = 0; i < nbits; i++) begin
			si_o = data[15-i];
			tick(2);
			sck_o = 1'b1;
			tick(2);
			sck_o = 1'b0;
		end
		tick(2);
		cs_n_o = 1'b1;
		si_o = ~si_o; // Released line must not show the last bit
		tick(6);
	endtask
endmodule // gsp_host_model

// >>> verif/gsp_protect_core_asserts.sv
// Port checker for the global sector protect core.
// Assumes it is bound to gsp_protect_core and sees only its ports.
`timescale 1ns/1ns
module gsp_protect_core_asserts #(
	parameter int NUM_SECTORS = 16,
	parameter int SECT_IDX_W = 4
) (
	// Observed ports
	input wire logic mclk_i,
	input wire logic reset_i,
	input wire logic cs_n_i,
	input wire logic wp_n_i,
	input wire logic sect_cmd_i,
	input wire logic sect_protect_i,
	input wire logic [SECT_IDX_W-1:0] sect_idx_i,
	input wire logic [NUM_SECTORS-1:0] sect_prot_o,
	input wire logic lock_o,
	input wire logic write_permit_o,
	input wire logic [7:0] status_o,
	input wire logic global_done_o
);
	// ****************************************************************
	// Properties
	// ****************************************************************
	default clocking @(posedge mclk_i); endclocking
	default disable iff (reset_i);
	// Summary of all sectors, as the status image should show it
	logic [1:0] sum_w;
	assign sum_w = (&sect_prot_o) ? 2'h3 : ((|sect_prot_o) ? 2'h1 : 2'h0);
	sequence s_pulse;
		global_done_o ##1 !global_done_o;
	endsequence
	reset_prot_a: assert property (disable iff (1'b0) reset_i |=> &sect_prot_o && !lock_o && !write_permit_o)
		else $error("reset state wrong");
	done_pulse_a: assert property (global_done_o |-> s_pulse)
		else $error("global pulse too long");
	done_uniform_a: assert property (global_done_o && !$past(sect_cmd_i) |-> &sect_prot_o || ~|sect_prot_o)
		else $error("global left mixed sectors");
	done_permit_a: assert property (global_done_o |-> $past(write_permit_o) && !write_permit_o)
		else $error("global without permit");
	done_unlocked_a: assert property (global_done_o |-> !$past(lock_o))
		else $error("global while locked");
	hw_lock_a: assert property (lock_o && !wp_n_i |=> lock_o && $stable(sect_prot_o))
		else $error("hard lock broken");
	sect_cmd_a: assert property (sect_cmd_i && !lock_o |=> sect_prot_o[$past(sect_idx_i)] == $past(sect_protect_i))
		else $error("sector command lost");
	frame_gate_a: assert property (!cs_n_i && !sect_cmd_i |=> $stable(sect_prot_o) && !global_done_o)
		else $error("update inside frame");
	status_img_a: assert property (!$past(reset_i) && !$past(reset_i, 2) |->
		status_o == {$past(lock_o), 2'h0, $past(wp_n_i), $past(sum_w), $past(write_permit_o), 1'b0})
		else $error("status image wrong");
endmodule // gsp_protect_core_asserts

// >>> verif/gsp_protect_core_tb.sv
// Self-checking bench for the global sector protect core.
// Assumes the host model and the bound checker compile beside it.
`timescale 1ns/1ns
module gsp_protect_core_tb;
	// ****************************************************************
	// Signals and instances
	// ****************************************************************
	logic mclk_i, reset_i, sck_i, cs_n_i, si_i, wp_n_i, sect_cmd_i, sect_protect_i;
	logic lock_o, write_permit_o, global_done_o, exp_lock, exp_wel;
	logic [3:0] sect_idx_i;
	logic [15:0] sect_prot_o, exp_prot;
	logic [7:0] status_o;
	int miscompares = 0;
	int comparisons = 0;
	gsp_host_model host (.mclk_i(mclk_i), .sck_o(sck_i), .cs_n_o(cs_n_i), .si_o(si_i));
	gsp_protect_core dut (.mclk_i(mclk_i), .reset_i(reset_i), .sck_i(sck_i), .cs_n_i(cs_n_i), .si_i(si_i),
		.wp_n_i(wp_n_i), .sect_cmd_i(sect_cmd_i), .sect_protect_i(sect_protect_i), .sect_idx_i(sect_idx_i),
		.sect_prot_o(sect_prot_o), .lock_o(lock_o), .write_permit_o(write_permit_o), .status_o(status_o),
		.global_done_o(global_done_o));
	// 50 MHz clock
	initial begin
		mclk_i = 1'b0;
		forever #10 mclk_i = ~mclk_i;
	end
	// ****************************************************************
	// Helpers
	// ****************************************************************
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Sectors, lock, permit and status against the bench's own reckoning; global_done_o is not checked
	task automatic check_state();
		logic [1:0] sum;
		sum = (&exp_prot) ? 2'h3 : ((|exp_prot) ? 2'h1 : 2'h0);
		chk("sectors", exp_prot, sect_prot_o);
		chk("lock", {15'h0, exp_lock}, {15'h0, lock_o});
		chk("permit", {15'h0, exp_wel}, {15'h0, write_permit_o});
		chk("status", {8'h0, exp_lock, 2'h0, wp_n_i, sum, exp_wel, 1'b0}, {8'h0, status_o});
	endtask
	// Status write, optionally preceded by the permit frame
	task automatic wsr(input logic [7:0] d, input logic wen);
		if (wen)
			host.frame(16'h0600, 8);
		host.frame({8'h01, d}, 16);
		if (wen && (wp_n_i || !exp_lock)) begin
			if (!exp_lock && d[5:2] == 4'hF)
				exp_prot = 16'hFFFF;
			if (!exp_lock && d[5:2] == 4'h0)
				exp_prot = 16'h0000;
			exp_lock = d[7];
		end
		exp_wel = 1'b0;
		check_state();
	endtask
	// One-cycle sector command, then let status settle
	task automatic sect(input logic [3:0] idx, input logic p);
		sect_cmd_i = 1'b1;
		sect_idx_i = idx;
		sect_protect_i = p;
		@(posedge mclk_i);
		#1;
		sect_cmd_i = 1'b0;
		if (!exp_lock)
			exp_prot[idx] = p;
		repeat (2) @(posedge mclk_i);
		#1;
	endtask
	task automatic do_reset();
		reset_i = 1'b1;
		repeat (12) @(posedge mclk_i);
		#1;
		reset_i = 1'b0;
		exp_prot = 16'hFFFF;
		exp_lock = 1'b0;
		exp_wel = 1'b0;
		repeat (3) @(posedge mclk_i);
		#1;
		check_state();
	endtask
	task automatic give_verdict();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic t_unlocked();
		wsr(8'h00, 1'b1);
		wsr(8'h04, 1'b1);
		wsr(8'h7F, 1'b1);
		wsr(8'h38, 1'b1);
	endtask
	task automatic t_sector();
		wsr(8'h00, 1'b1);
		sect(4'hF, 1'b1);
		sect(4'h0, 1'b1);
		sect(4'h0, 1'b0);
		check_state();
		wsr(8'hFF, 1'b1);
		sect(4'h3, 1'b0);
		check_state();
	endtask
	task automatic t_soft();
		wsr(8'h00, 1'b1);
		wsr(8'h00, 1'b1);
		wsr(8'hF0, 1'b1);
		wsr(8'h0F, 1'b1);
		wsr(8'h83, 1'b1);
	endtask
	task automatic t_permit();
		wsr(8'h0F, 1'b1);
		wsr(8'hFF, 1'b0);
		host.frame(16'h0600, 8);
		exp_wel = 1'b1;
		check_state();
		host.frame(16'h01FF, 12);
		exp_wel = 1'b0;
		check_state();
	endtask
	task automatic t_hard();
		wsr(8'hF0, 1'b1);
		wp_n_i = 1'b0;
		wsr(8'h00, 1'b1);
		sect(4'h2, 1'b1);
		check_state();
		wp_n_i = 1'b1;
		do_reset();
	endtask
	// Main sequence
	initial begin
		reset_i = 1'b1;
		wp_n_i = 1'b1;
		sect_cmd_i = 1'b0;
		sect_protect_i = 1'b0;
		sect_idx_i = 4'h0;
		do_reset();
		t_unlocked();
		t_sector();
		t_soft();
		t_permit();
		t_hard();
		give_verdict();
	end
	// Watchdog: the run needs just under a tenth of this span
	initial begin
		#400000;
		miscompares++;
		give_verdict();
	end
endmodule // gsp_protect_core_tb

bind gsp_protect_core gsp_protect_core_asserts #(.NUM_SECTORS(NUM_SECTORS), .SECT_IDX_W(SECT_IDX_W)) chk_i (
	.mclk_i(mclk_i), .reset_i(reset_i), .cs_n_i(cs_n_i), .wp_n_i(wp_n_i), .sect_cmd_i(sect_cmd_i),
	.sect_protect_i(sect_protect_i), .sect_idx_i(sect_idx_i), .sect_prot_o(sect_prot_o), .lock_o(lock_o),
	.write_permit_o(write_permit_o), .status_o(status_o), .global_done_o(global_done_o));
